/* verilog/cagw_wait_ctrl.sv */
// Effective address generation, program counter advance and wait control.
// Assumes decoded instruction fields arrive synchronous to clk, with the
// operand bytes and the tested memory byte already fetched by the core.
`timescale 1ns/10ps
module cagw_wait_ctrl (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Decoded instruction and its strobe.
    input wire logic instrValid,
    input wire logic [9:0] instrMode,
    input wire logic isStop,
    // Operand bytes that follow the opcode.
    input wire logic [7:0] operandFirst,
    input wire logic [7:0] operandSecond,
    // Index register and branch condition.
    input wire logic [7:0] indexReg,
    input wire logic branchCond,
    // Bit selection and the byte that holds the bit.
    input wire logic [2:0] bitNum,
    input wire logic bitSetSel,
    input wire logic [7:0] memByte,
    // Address results.
    output logic [15:0] effectiveAddress,
    output logic [15:0] programCounter,
    // Bit results and status.
    output logic [7:0] modifiedByte,
    output logic carryFlag,
    output logic intMask,
    output logic intEntry,
    // Control link.
    cagw_wait_if.ctrl wc
);
    // State of the wait controller.
    cagw_pkg::cagw_state_t st_q, st_d;
    logic intMask_q, intMask_d;
    logic intEntry_q, intEntry_d;

    // State of the instruction datapath.
    logic [15:0] programCounter_q, programCounter_d;
    logic [15:0] effectiveAddr_q, effectiveAddr_d;
    logic [7:0] modifiedByte_q, modifiedByte_d;
    logic carryFlag_q, carryFlag_d;

    // Qualifiers that decide whether an instruction is taken.
    logic intTake;
    logic takeInstr;

    // Program counter increments for the three instruction lengths.
    logic [15:0] pcPlusOne;
    logic [15:0] pcPlusTwo;
    logic [15:0] pcPlusThree;

    // Branch offsets and targets.
    logic [15:0] relOffset;
    logic [15:0] btbOffset;
    logic [15:0] relTarget;
    logic [15:0] branchTargetAddress;

    // Indexed sums and bit handling.
    logic [8:0] ix1Sum;
    logic [8:0] ix2Low;
    logic [7:0] ix2High;
    logic [15:0] testByteAddress;
    logic testedBit;
    logic [7:0] bitMask;

    // An enabled interrupt request, seen only while the mask is clear.
    assign intTake = wc.intReq && !intMask_q;

    // Instructions run only in the run state and only when no wait,
    // interrupt or watchdog event competes, so the datapath holds while
    // the processor clock is stopped, until a watchdog expiry resets it.
    assign takeInstr = instrValid && (st_q == cagw_pkg::ST_RUN)
        && !wc.waitReq && !intTake && !wc.wdogExpire;

    // Increments of the program counter.
    assign pcPlusOne = programCounter_q + cagw_pkg::STEP_ONE;
    assign pcPlusTwo = programCounter_q + cagw_pkg::STEP_TWO;
    assign pcPlusThree = programCounter_q + cagw_pkg::STEP_THREE;

    // Sign extension of the relative offsets and the two branch targets.
    assign relOffset = {{8{operandFirst[7]}}, operandFirst};
    assign btbOffset = {{8{operandSecond[7]}}, operandSecond};
    assign relTarget = pcPlusTwo + relOffset;
    assign branchTargetAddress = pcPlusThree + btbOffset;

    // Unsigned index sums; the ninth bit carries into the high byte.
    assign ix1Sum = {1'b0, indexReg} + {1'b0, operandFirst};
    assign ix2Low = {1'b0, indexReg} + {1'b0, operandSecond};
    assign ix2High = operandFirst + {7'h00, ix2Low[8]};

    // Direct address of the byte that a bit instruction works on.
    assign testByteAddress = {cagw_pkg::ZERO_BYTE, operandFirst};
    assign testedBit = memByte[bitNum];
    assign bitMask = 8'h01 << bitNum;

    // Next values of the wait controller; a watchdog expiry wins over all.
    always_comb
    begin
        st_d = st_q;
        intMask_d = intMask_q;
        intEntry_d = 1'b0;
        if (wc.wdogExpire)
        begin
            st_d = cagw_pkg::ST_RUN;
            intMask_d = cagw_pkg::I_MASK_RESET;
        end
        else
        begin
            unique case (st_q)
                cagw_pkg::ST_RUN:
                begin
                    if (wc.waitReq)
                    begin
                        st_d = cagw_pkg::ST_WAIT;
                        intMask_d = 1'b0;
                    end
                    else if (intTake)
                    begin
                        intEntry_d = 1'b1;
                        intMask_d = 1'b1;
                    end
                end
                cagw_pkg::ST_WAIT:
                begin
                    if (wc.intReq)
                    begin
                        st_d = cagw_pkg::ST_WAKE;
                    end
                end
                cagw_pkg::ST_WAKE:
                begin
                    st_d = cagw_pkg::ST_RUN;
                    intEntry_d = 1'b1;
                    intMask_d = 1'b1;
                end
                default:
                begin
                    st_d = cagw_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Register the wait controller.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q <= cagw_pkg::ST_RUN;
            intMask_q <= cagw_pkg::I_MASK_RESET;
            intEntry_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            intMask_q <= intMask_d;
            intEntry_q <= intEntry_d;
        end
    end

    // Next values of the datapath, one addressing mode per arm.
    always_comb
    begin
        programCounter_d = programCounter_q;
        effectiveAddr_d = effectiveAddr_q;
        modifiedByte_d = modifiedByte_q;
        carryFlag_d = carryFlag_q;
        if (wc.wdogExpire)
        begin
            programCounter_d = cagw_pkg::PC_RESET;
            effectiveAddr_d = {cagw_pkg::ZERO_BYTE, cagw_pkg::ZERO_BYTE};
            modifiedByte_d = cagw_pkg::ZERO_BYTE;
            carryFlag_d = cagw_pkg::CARRY_RESET;
        end
        else if (takeInstr)
        begin
            unique case (instrMode)
                cagw_pkg::MODE_INH:
                begin
                    // Stop is decoded here as well and leaves the mask.
                    programCounter_d = pcPlusOne;
                end
                cagw_pkg::MODE_IMM:
                begin
                    effectiveAddr_d = pcPlusOne;
                    programCounter_d = pcPlusTwo;
                end
                cagw_pkg::MODE_DIR:
                begin
                    effectiveAddr_d = testByteAddress;
                    programCounter_d = pcPlusTwo;
                end
                cagw_pkg::MODE_EXT:
                begin
                    effectiveAddr_d = {operandFirst, operandSecond};
                    programCounter_d = pcPlusThree;
                end
                cagw_pkg::MODE_IX0:
                begin
                    effectiveAddr_d = {cagw_pkg::ZERO_BYTE, indexReg};
                    programCounter_d = pcPlusOne;
                end
                cagw_pkg::MODE_IX1:
                begin
                    effectiveAddr_d = {7'h00, ix1Sum};
                    programCounter_d = pcPlusTwo;
                end
                cagw_pkg::MODE_IX2:
                begin
                    effectiveAddr_d = {ix2High, ix2Low[7:0]};
                    programCounter_d = pcPlusThree;
                end
                cagw_pkg::MODE_REL:
                begin
                    // The target is used only when the condition holds.
                    if (branchCond)
                    begin
                        effectiveAddr_d = relTarget;
                        programCounter_d = relTarget;
                    end
                    else
                    begin
                        effectiveAddr_d = pcPlusTwo;
                        programCounter_d = pcPlusTwo;
                    end
                end
                cagw_pkg::MODE_BSC:
                begin
                    effectiveAddr_d = testByteAddress;
                    programCounter_d = pcPlusTwo;
                    if (bitSetSel)
                    begin
                        modifiedByte_d = memByte | bitMask;
                    end
                    else
                    begin
                        modifiedByte_d = memByte & ~bitMask;
                    end
                end
                cagw_pkg::MODE_BTB:
                begin
                    effectiveAddr_d = testByteAddress;
                    carryFlag_d = testedBit;
                    if (testedBit == bitSetSel)
                    begin
                        programCounter_d = branchTargetAddress;
                    end
                    else
                    begin
                        programCounter_d = pcPlusThree;
                    end
                end
                default:
                begin
                    // An illegal mode code leaves the datapath untouched.
                    programCounter_d = programCounter_q;
                end
            endcase
        end
    end

    // Register the datapath.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            programCounter_q <= cagw_pkg::PC_RESET;
            effectiveAddr_q <= {cagw_pkg::ZERO_BYTE, cagw_pkg::ZERO_BYTE};
            modifiedByte_q <= cagw_pkg::ZERO_BYTE;
            carryFlag_q <= cagw_pkg::CARRY_RESET;
        end
        else
        begin
            programCounter_q <= programCounter_d;
            effectiveAddr_q <= effectiveAddr_d;
            modifiedByte_q <= modifiedByte_d;
            carryFlag_q <= carryFlag_d;
        end
    end

    // Outputs come straight from the flip-flops.
    assign effectiveAddress = effectiveAddr_q;
    assign programCounter = programCounter_q;
    assign modifiedByte = modifiedByte_q;
    assign carryFlag = carryFlag_q;
    assign intMask = intMask_q;
    assign intEntry = intEntry_q;

    // The processor clock runs in every state except wait.
    assign wc.cpuRun = (st_q != cagw_pkg::ST_WAIT);

    // A wait request in the run state stops the processor clock.
    property p_waitHalts;
        @(posedge clk) disable iff (!nrst)
        (st_q == cagw_pkg::ST_RUN && wc.waitReq && !wc.wdogExpire)
        |=> !wc.cpuRun;
    endproperty
    a_waitHalts: assert property (p_waitHalts)
        else $error("wait did not halt the processor");

    // Entering wait clears the interrupt mask.
    property p_waitClearsMask;
        @(posedge clk) disable iff (!nrst)
        (st_q == cagw_pkg::ST_RUN && wc.waitReq && !wc.wdogExpire)
        |=> !intMask_q;
    endproperty
    a_waitClearsMask: assert property (p_waitClearsMask)
        else $error("wait left the interrupt mask set");

    // The program counter and effective address do not move while waiting.
    property p_waitHolds;
        @(posedge clk) disable iff (!nrst)
        (!wc.cpuRun && !wc.wdogExpire)
        |=> ($stable(programCounter_q) && $stable(effectiveAddr_q));
    endproperty
    a_waitHolds: assert property (p_waitHolds)
        else $error("datapath changed while waiting");

    // Waking goes straight into interrupt entry with the clock running.
    property p_wakeEntry;
        @(posedge clk) disable iff (!nrst)
        (st_q == cagw_pkg::ST_WAKE && !wc.wdogExpire)
        |=> (intEntry_q && wc.cpuRun);
    endproperty
    a_wakeEntry: assert property (p_wakeEntry)
        else $error("wake did not enter the interrupt");

    // Stop only advances the program counter and keeps the mask.
    property p_stopNop;
        @(posedge clk) disable iff (!nrst)
        (takeInstr && isStop && instrMode == cagw_pkg::MODE_INH)
        |=> ($stable(intMask_q) && programCounter_q == $past(pcPlusOne));
    endproperty
    a_stopNop: assert property (p_stopNop)
        else $error("stop did not act as a no-operation");

    // The tested bit lands in the carry flag.
    property p_btbCarry;
        @(posedge clk) disable iff (!nrst)
        (takeInstr && instrMode == cagw_pkg::MODE_BTB)
        |=> (carryFlag_q == $past(testedBit));
    endproperty
    a_btbCarry: assert property (p_btbCarry)
        else $error("carry does not hold the tested bit");

    // Direct addresses stay in the lowest page.
    property p_dirHigh;
        @(posedge clk) disable iff (!nrst)
        (takeInstr && instrMode == cagw_pkg::MODE_DIR)
        |=> (effectiveAddr_q[15:8] == cagw_pkg::ZERO_BYTE);
    endproperty
    a_dirHigh: assert property (p_dirHigh)
        else $error("direct address left the lowest page");
endmodule : cagw_wait_ctrl

/* verilog/cagw_pkg.sv */
// Constants shared by the address generation and wait control block.
// Assumes a single clock domain with synchronous active-low reset.
package cagw_pkg;
    // Addressing mode selector, one-hot.
    typedef enum logic [9:0] {
        MODE_INH = 10'h001,
        MODE_IMM = 10'h002,
        MODE_DIR = 10'h004,
        MODE_EXT = 10'h008,
        MODE_IX0 = 10'h010,
        MODE_IX1 = 10'h020,
        MODE_IX2 = 10'h040,
        MODE_REL = 10'h080,
        MODE_BSC = 10'h100,
        MODE_BTB = 10'h200
    } cagw_mode_t;
    // Wait controller states, one-hot.
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_WAIT = 3'h2,
        ST_WAKE = 3'h4
    } cagw_state_t;
    // Program counter steps per instruction length.
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_TWO = 16'h0002;
    localparam logic [15:0] STEP_THREE = 16'h0003;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // Reset values of the interrupt mask and the carry flag.
    localparam logic I_MASK_RESET = 1'b1;
    localparam logic CARRY_RESET = 1'b0;
    // Watchdog timeout in clock cycles, counted through wait as well.
    localparam int WDOG_CYCLES = 114688;
    localparam int WDOG_W = 17;
endpackage : cagw_pkg

/* verilog/cagw_wait_if.sv */
// Interface carrying wait and watchdog signals between modules.
// Assumes one clock domain shared by all users.
`timescale 1ns/10ps
interface cagw_wait_if;
    logic waitReq;
    logic intReq;
    logic cpuRun;
    logic wdogService;
    logic wdogExpire;
    modport ctrl (input waitReq, input intReq, output cpuRun,
        input wdogExpire);
    modport dog (input wdogService, output wdogExpire);
    modport core (output waitReq, output intReq, output wdogService,
        input cpuRun, input wdogExpire);
endinterface : cagw_wait_if

/* verilog/cagw_watchdog.sv */
// Free running watchdog timer that cannot be disabled.
// Assumes the peripheral clock keeps running during wait.
`timescale 1ns/10ps
module cagw_watchdog #(
    parameter int TIMEOUT = cagw_pkg::WDOG_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Service and expiry.
    cagw_wait_if.dog wd
);
    logic [cagw_pkg::WDOG_W-1:0] cnt_q, cnt_d;
    logic exp_q, exp_d;

    // Count every cycle, including wait, and restart on service.
    always_comb
    begin
        exp_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
        if (wd.wdogService)
        begin
            cnt_d = '0;
        end
        else if (cnt_q == TIMEOUT[cagw_pkg::WDOG_W-1:0] - 1'b1)
        begin
            cnt_d = '0;
            exp_d = 1'b1;
        end
    end

    // Register the counter.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            exp_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end
    assign wd.wdogExpire = exp_q;

    property p_expire;
        @(posedge clk) disable iff (!nrst)
        (cnt_q == TIMEOUT[cagw_pkg::WDOG_W-1:0] - 1'b1 && !wd.wdogService)
        |=> wd.wdogExpire;
    endproperty
    a_expire: assert property (p_expire) else $error("no expiry");
endmodule : cagw_watchdog

/* test/cagw_core_model.sv */
// Core side of the wait link.
// Assumes bench commands change at the clock edge.
`timescale 1ns/10ps
module cagw_core_model (
    // Clock and commands.
    input wire logic clk,
    input wire logic doWait,
    input wire logic doInt,
    input wire logic doSvc,
    // Link.
    cagw_wait_if.core cx
);
    // Puts the commands on the link.
    always_ff @(posedge clk)
    begin
        cx.waitReq <= doWait;
        cx.intReq <= doInt;
        cx.wdogService <= doSvc;
    end
endmodule : cagw_core_model

/* test/cpu_address_gen_and_wait_bench.sv */
// Bench for address generation, wait control and watchdog.
// Assumes a short watchdog count.
`timescale 1ns/10ps
module cpu_address_gen_and_wait_bench;
    localparam int TO = 64;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic doWait = 1'b0;
    logic doInt = 1'b0;
    logic doSvc = 1'b0;
    logic instrValid = 1'b0;
    logic [9:0] instrMode = 10'h001;
    logic isStop = 1'b0;
    logic [7:0] opA = 8'h00;
    logic [7:0] opB = 8'h00;
    logic [7:0] idx = 8'h00;
    logic cond = 1'b0;
    logic [2:0] bitNum = 3'h0;
    logic bitSel = 1'b0;
    logic [7:0] mem = 8'h00;
    logic [15:0] effectiveAddress;
    logic [15:0] programCounter;
    logic [7:0] modifiedByte;
    logic carryFlag;
    logic intMask;
    logic intEntry;
    int n_errors = 0;
    int checked = 0;
    int runExp = 1;
    int k = 0;
    int pcM = 0;
    int eaM = 0;
    int datM = 0;
    int cyM = 0;
    bit [31:0] seed = 32'h6E99;
    cagw_wait_if w();
    cagw_wait_ctrl dut_u (.clk(clk), .nrst(nrst), .instrValid(instrValid),
        .instrMode(instrMode), .isStop(isStop), .operandFirst(opA),
        .operandSecond(opB), .indexReg(idx), .branchCond(cond),
        .bitNum(bitNum), .bitSetSel(bitSel), .memByte(mem),
        .effectiveAddress(effectiveAddress),
        .programCounter(programCounter), .modifiedByte(modifiedByte),
        .carryFlag(carryFlag), .intMask(intMask), .intEntry(intEntry),
        .wc(w.ctrl));
    cagw_watchdog #(.TIMEOUT(TO)) dog_u (.clk(clk), .nrst(nrst), .wd(w.dog));
    cagw_core_model core_u (.clk(clk), .doWait(doWait), .doInt(doInt),
        .doSvc(doSvc), .cx(w.core));
    // Clock.
    always #12.5 clk = ~clk;
    // Xorshift step for the random stimulus.
    function automatic bit [31:0] xs(input bit [31:0] s);
        bit [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        r = r ^ (r << 5);
        return r;
    endfunction : xs
    // Signed value of an offset byte.
    function automatic int sx(input logic [7:0] b);
        return b[7] ? int'(b) - 256 : int'(b);
    endfunction : sx
    // Compares one result with the model.
    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    // Random instructions, each compared with the integer model.
    task automatic addr_test(input int n);
        for (int i = 0; i < n; i++)
        begin
            seed = xs(seed);
            k = seed % 10;
            @(posedge clk);
            instrValid <= 1'b1;
            instrMode <= 10'h001 << k;
            isStop <= seed[20];
            opA <= seed[7:0];
            opB <= seed[15:8];
            idx <= seed[23:16];
            cond <= seed[24];
            bitNum <= seed[27:25];
            bitSel <= seed[28];
            mem <= seed[31:24] ^ seed[11:4];
            @(posedge clk);
            instrValid <= 1'b0;
            #1;
            case (k)
                0:
                begin
                    pcM = (pcM + 1) & 32'h0000FFFF;
                    check("pc", pcM, programCounter);
                    check("mask", cagw_pkg::I_MASK_RESET, intMask);
                end
                1:
                begin
                    eaM = (pcM + 1) & 32'h0000FFFF;
                    pcM = (pcM + 2) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                2:
                begin
                    eaM = opA;
                    pcM = (pcM + 2) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                3:
                begin
                    eaM = opA * 256 + opB;
                    pcM = (pcM + 3) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                4:
                begin
                    eaM = idx;
                    pcM = (pcM + 1) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                5:
                begin
                    eaM = idx + opA;
                    pcM = (pcM + 2) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                6:
                begin
                    eaM = (opA * 256 + idx + opB) & 32'h0000FFFF;
                    pcM = (pcM + 3) & 32'h0000FFFF;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                7:
                begin
                    pcM = (pcM + 2 + (cond ? sx(opA) : 0)) & 32'h0000FFFF;
                    eaM = pcM;
                    check("ea", eaM, effectiveAddress);
                    check("pc", pcM, programCounter);
                end
                8:
                begin
                    eaM = opA;
                    pcM = (pcM + 2) & 32'h0000FFFF;
                    datM = bitSel ? (mem | (1 << bitNum))
                        : (mem & ~(1 << bitNum) & 255);
                    check("ea", eaM, effectiveAddress);
                    check("data", datM, modifiedByte);
                end
                default:
                begin
                    eaM = opA;
                    cyM = (mem >> bitNum) & 1;
                    pcM = (pcM + 3 + (cyM == bitSel ? sx(opB) : 0))
                        & 32'h0000FFFF;
                    check("carry", cyM, carryFlag);
                    check("pc", pcM, programCounter);
                    check("ea", eaM, effectiveAddress);
                end
            endcase
        end
    endtask : addr_test
    // Waits for a value, then compares it.
    task automatic await(input bit dog, input logic exp, input int lim);
        logic v;
        for (int k = 0; k < lim; k++)
        begin
            @(posedge clk);
            #1 v = dog ? w.wdogExpire : w.cpuRun;
            if (v === exp) break;
        end
        checked++;
        if (v !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %b got %b", dog ? "expire" : "run", exp, v);
            tally_and_finish();
        end
    endtask : await
    // Verdict.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Address test, then wait and wake rounds, then a watchdog expiry while waiting.
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        doSvc <= 1'b1;
        await(1'b0, 1'(runExp), 4);
        addr_test(200);
        $display("address test done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {doSvc, doWait} <= 2'h3;
            @(posedge clk);
            {doSvc, doWait} <= 2'h0;
            runExp = 0;
            await(1'b0, 1'(runExp), 8);
            check("mask", 1'b0, intMask);
            seed = xs(seed);
            repeat (seed % 16) @(posedge clk);
            await(1'b0, 1'(runExp), 1);
            check("hold", pcM, programCounter);
            @(posedge clk);
            doInt <= 1'b1;
            runExp = 1;
            await(1'b0, 1'(runExp), 8);
            @(posedge clk);
            #1 check("entry", 1'b1, intEntry);
            @(posedge clk);
            doInt <= 1'b0;
        end
        $display("wake rounds done");
        @(posedge clk);
        doWait <= 1'b1;
        await(1'b1, 1'b1, TO + 8);
        $display("watchdog test done");
        tally_and_finish();
    end
endmodule : cpu_address_gen_and_wait_bench
